//--- rtl/avb_body_builder.sv
`timescale 1ns/1ps
module avb_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic wr, rd;
  always_comb begin
    // Compare at counter width; a pointer-width cast of the depth would wrap to zero
    wr = in_valid && (cnt_reg != (AW+1)'(DEPTH));
    rd = out_ready && (cnt_reg != '0);
    wp_next = wr ? wp_reg + 1'b1 : wp_reg;
    rp_next = rd ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
    in_ready = cnt_reg != (AW+1)'(DEPTH);
    out_valid = cnt_reg != '0;
    out_data = mem[rp_reg];
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule // avb_fifo

module avb_body_builder (
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration
  input wire avb_pkg::avb_cfg_t cfg,
  input wire logic [7:0] packet_flags,
  input wire logic [63:0] abs_time,
  input wire logic count_known,
  input wire logic tick_10mhz,
  // Body request
  input wire logic body_start,
  input wire logic [11:0] body_packets,
  output logic body_busy,
  // Stream packets, 32-bit words, last marks packet end
  input wire logic [31:0] strm_data,
  input wire logic strm_last,
  input wire logic strm_valid,
  output logic strm_ready,
  // Body output
  output logic [31:0] body_data,
  output logic body_last,
  output logic body_valid,
  input wire logic body_ready,
  // Clock reference
  output logic [41:0] clock_ref
);
  typedef enum logic [2:0] {S_IDLE, S_CHAN, S_LOW, S_HIGH, S_DATA} avb_state_t;
  avb_state_t st_reg, st_next;
  logic [11:0] left_reg, left_next, count_reg, count_next;
  logic [63:0] stamp_reg, stamp_next;
  logic [47:0] rtc_reg, rtc_next;
  logic [32:0] fin_data;
  logic fin_valid, fin_ready, fout_valid;
  logic [32:0] fout_data;
  logic [31:0] word;
  logic [32:0] base_reg, base_next;
  logic [8:0] ext_reg, ext_next;
  logic [4:0] acc_reg, acc_next;
  logic [41:0] ref_reg, ref_next;
  logic out_v_reg, out_v_next, out_l_reg, out_l_next, busy_reg, busy_next;
  logic [31:0] out_d_reg, out_d_next;
  logic sr_reg, sr_next;
  logic rdy_reg, rdy_next;
  logic [3:0] occ_reg, occ_next;

  function automatic logic [31:0] chan_word(input avb_pkg::avb_cfg_t c, input logic [11:0] n);
    logic [31:0] w;
    w = 32'h0;
    w[avb_pkg::AUDIO_BIT] = c.audio_coding_select;
    w[avb_pkg::GRADE_LSB +: 4] = c.video_grade_code;
    w[avb_pkg::KLV_BIT] = c.klv_flag;
    w[avb_pkg::SYNC_BIT] = c.clock_sync_flag;
    w[avb_pkg::STAMP_BIT] = c.per_packet_stamp_flag;
    // Reserved profile codes are passed through; checking is the host's job
    w[avb_pkg::PROF_LSB +: 4] = c.video_profile_code;
    w[avb_pkg::ETIME_BIT] = c.embedded_time_flag;
    w[avb_pkg::RATE_BIT] = c.rate_mode_flag;
    w[avb_pkg::KIND_BIT] = c.stream_kind_flag;
    w[11:0] = n;
    return w;
  endfunction

  always_comb begin
    st_next = st_reg;
    left_next = left_reg;
    count_next = count_reg;
    stamp_next = stamp_reg;
    fin_valid = 1'b0;
    fin_data = '0;
    word = chan_word(cfg, count_reg);
    unique case (st_reg)
      S_IDLE: begin
        if (body_start) begin
          left_next = body_packets;
          count_next = count_known ? body_packets : 12'h000;
          st_next = S_CHAN;
        end
      end
      S_CHAN: begin
        fin_valid = 1'b1;
        fin_data = {word, left_reg == 12'h000};
        if (fin_ready) begin
          st_next = (left_reg == 12'h000) ? S_IDLE : (cfg.per_packet_stamp_flag ? S_LOW : S_DATA);
        end
      end
      S_LOW: begin
        fin_valid = 1'b1;
        fin_data = {stamp_reg[31:0], 1'b0};
        if (fin_ready) st_next = S_HIGH;
      end
      S_HIGH: begin
        fin_valid = 1'b1;
        fin_data = {stamp_reg[63:32], 1'b0};
        if (fin_ready) st_next = S_DATA;
      end
      S_DATA: begin
        // Packets pass whole; the body ends only on a packet's last word
        fin_valid = strm_valid && rdy_reg;
        fin_data = {strm_data, strm_last && left_reg == 12'h001};
        if (strm_valid && rdy_reg && strm_last) begin
          left_next = left_reg - 12'h001;
          st_next = (left_reg == 12'h001) ? S_IDLE : (cfg.per_packet_stamp_flag ? S_LOW : S_DATA);
        end
      end
    endcase
    // Stamp is latched on entry to a packet so it marks the first bit's time
    if (st_next == S_LOW && st_reg != S_LOW) begin
      stamp_next = packet_flags[avb_pkg::FLAG_ABS_BIT] ? abs_time : {16'h0000, rtc_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= S_IDLE;
      left_reg <= 12'h000;
      count_reg <= 12'h000;
      stamp_reg <= 64'h0;
    end else begin
      st_reg <= st_next;
      left_reg <= left_next;
      count_reg <= count_next;
      stamp_reg <= stamp_next;
    end
  end

  avb_fifo #(.WIDTH(33), .DEPTH(avb_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_data(fin_data),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .out_data(fout_data),
    .out_valid(fout_valid),
    .out_ready(!out_v_reg || body_ready)
  );

  // Output stage: registered skid of one word
  always_comb begin
    out_v_next = out_v_reg;
    out_d_next = out_d_reg;
    out_l_next = out_l_reg;
    if (!out_v_reg || body_ready) begin
      out_v_next = fout_valid;
      out_d_next = fout_data[32:1];
      out_l_next = fout_data[0];
    end
    // The state term bridges the cycle in which the last word is still entering the buffer
    busy_next = (st_next != S_IDLE) || (st_reg != S_IDLE) || fout_valid || out_v_next;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_v_reg <= 1'b0;
      out_d_reg <= 32'h0;
      out_l_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      out_v_reg <= out_v_next;
      out_d_reg <= out_d_next;
      out_l_reg <= out_l_next;
      busy_reg <= busy_next;
    end
  end

  // Registered stream ready from a mirror of the buffer fill; it only promises room that exists
  always_comb begin
    occ_next = occ_reg + 4'(fin_valid && fin_ready) - 4'(fout_valid && (!out_v_reg || body_ready));
    rdy_next = (st_next == S_DATA) && (occ_next != 4'(avb_pkg::FIFO_DEPTH));
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      occ_reg <= 4'h0;
      rdy_reg <= 1'b0;
    end else begin
      occ_reg <= occ_next;
      rdy_reg <= rdy_next;
    end
  end

  // Relative time and 27 MHz reference slaved to the 10 MHz tick
  always_comb begin
    rtc_next = tick_10mhz ? rtc_reg + 48'h1 : rtc_reg;
    sr_next = cfg.clock_sync_flag;
    base_next = base_reg;
    ext_next = ext_reg;
    acc_next = acc_reg;
    if (sr_reg && tick_10mhz) begin
      // 2.7 reference ticks per 10 MHz tick; fractional accumulator spreads them
      acc_next = acc_reg + 5'h07;
      ext_next = ext_reg + 9'h002;
      if (acc_reg + 5'h07 >= avb_pkg::REF_DEN) begin
        acc_next = acc_reg + 5'h07 - avb_pkg::REF_DEN;
        ext_next = ext_reg + 9'h003;
      end
      if (ext_next > avb_pkg::EXT_MOD_LAST) begin
        ext_next = ext_next - 9'h12c;
        base_next = base_reg + 33'h1;
      end
    end
    ref_next = 42'(base_reg) * 42'h12c + 42'(ext_reg);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rtc_reg <= avb_pkg::RTC_RESET;
      sr_reg <= 1'b0;
      base_reg <= 33'h0;
      ext_reg <= 9'h000;
      acc_reg <= 5'h00;
      ref_reg <= 42'h0;
    end else begin
      rtc_reg <= rtc_next;
      sr_reg <= sr_next;
      base_reg <= base_next;
      ext_reg <= ext_next;
      acc_reg <= acc_next;
      ref_reg <= ref_next;
    end
  end

  assign body_data = out_d_reg;
  assign body_last = out_l_reg;
  assign body_valid = out_v_reg;
  assign body_busy = busy_reg;
  assign clock_ref = ref_reg;
  assign strm_ready = rdy_reg;

  sequence seq_chan_taken;
    st_reg == S_CHAN && fin_ready;
  endsequence
  AST_CHAN_FIRST: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_IDLE && body_start |=> st_reg == S_CHAN) else $error("body does not open with channel word");
  AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_CHAN |-> fin_data[32:28] == 5'h00) else $error("reserved bits not zero");
  AST_AUDIO_BIT: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_CHAN |-> fin_data[27] == cfg.audio_coding_select) else $error("audio bit wrong");
  AST_GRADE_FIELD: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_CHAN |-> fin_data[26:23] == cfg.video_grade_code) else $error("grade field wrong");
  AST_COUNT_FIELD: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_CHAN && count_reg != 12'h000 |-> fin_data[12:1] == left_reg) else $error("count field wrong");
  AST_READY_ROOM: assert property (@(posedge clk_sys) disable iff (!nrst)
    strm_ready |-> fin_ready) else $error("stream ready without buffer room");
  AST_COUNT_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_IDLE && body_start && !count_known |=> count_reg == 12'h000) else $error("unknown count not zero");
  AST_STAMP_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_LOW && fin_ready |=> st_reg == S_HIGH) else $error("stamp words not contiguous");
  AST_HIGH_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_HIGH && !packet_flags[avb_pkg::FLAG_ABS_BIT] |-> fin_data[32:17] == 16'h0000)
    else $error("high word upper bits not zero");
  AST_STAMP_NEXT: assert property (@(posedge clk_sys) disable iff (!nrst)
    seq_chan_taken ##0 left_reg != 12'h000 ##0 cfg.per_packet_stamp_flag |=> st_reg == S_LOW)
    else $error("stamp missing");
  AST_EXT_RANGE: assert property (@(posedge clk_sys) disable iff (!nrst)
    ext_reg <= avb_pkg::EXT_MOD_LAST) else $error("extension beyond 299");
  AST_WHOLE_PKT: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg == S_DATA && !(strm_valid && strm_last && rdy_reg) |=> st_reg == S_DATA)
    else $error("packet split");
endmodule // avb_body_builder

//--- rtl/avb_pkg.sv
package avb_pkg;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int AUDIO_BIT = 26;
  localparam int GRADE_LSB = 22;
  localparam int KLV_BIT = 21;
  localparam int SYNC_BIT = 20;
  localparam int STAMP_BIT = 19;
  localparam int PROF_LSB = 15;
  localparam int ETIME_BIT = 14;
  localparam int RATE_BIT = 13;
  localparam int KIND_BIT = 12;
  localparam int FLAG_ABS_BIT = 6;
  localparam logic [3:0] PROF_MAX = 4'h6;
  localparam logic [8:0] EXT_MOD_LAST = 9'h12b;
  // 27 MHz from 10 MHz: 27 reference ticks per 10 counter ticks
  localparam logic [4:0] REF_NUM = 5'h1b;
  localparam logic [4:0] REF_DEN = 5'h0a;
  localparam logic [47:0] RTC_RESET = 48'h0;

  typedef struct packed {
    logic audio_coding_select;
    logic [3:0] video_grade_code;
    logic klv_flag;
    logic clock_sync_flag;
    logic per_packet_stamp_flag;
    logic [3:0] video_profile_code;
    logic embedded_time_flag;
    logic rate_mode_flag;
    logic stream_kind_flag;
  } avb_cfg_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
  } avb_beat_t;
endpackage

//--- verification/avb_enc_model.sv
`timescale 1ns/1ps
module avb_enc_model #(
  parameter int PKT_W = 3
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [11:0] pkts,
  input wire logic slow,
  // Stream
  output logic [31:0] strm_data,
  output logic strm_last,
  output logic strm_valid,
  input wire logic strm_ready
);
  int p;
  int w;
  initial begin
    strm_data = 32'h0;
    strm_last = 1'b0;
    strm_valid = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        // One program, audio already muxed in; whole packets only
        for (p = 0; p < pkts; p++) begin
          for (w = 0; w < PKT_W; w++) begin
            #1;
            strm_data = {16'h5e00 + p[15:0], w[15:0]};
            strm_last = (w == PKT_W - 1);
            strm_valid = 1'b1;
            do @(posedge clk_sys); while (strm_ready !== 1'b1);
            if (slow) begin
              #1;
              strm_valid = 1'b0;
              strm_data = ~strm_data;
              @(posedge clk_sys);
            end
          end
        end
        #1;
        strm_valid = 1'b0;
        // Idle bus shows no stale word
        strm_data = ~strm_data;
      end
    end
  end
endmodule // avb_enc_model

//--- verification/test_avc_video_packet_body_builder.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_avc_video_packet_body_builder;
  localparam int PKT_W = 3;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  avb_pkg::avb_cfg_t cfg = '0;
  logic [7:0] pflags = 8'h0;
  logic [63:0] abs_t = 64'h0;
  logic known = 1'b1;
  logic tick = 1'b0;
  logic body_start = 1'b0;
  logic [11:0] body_packets = 12'h0;
  logic body_busy, strm_last, strm_valid, strm_ready, body_last, body_valid;
  logic [31:0] strm_data, body_data;
  logic body_ready = 1'b1;
  logic [41:0] clock_ref;
  logic go = 1'b0, slow = 1'b0, hold = 1'b0, toggle = 1'b0;
  logic [47:0] rtc = 48'h0;
  logic [32:0] exp_q[$], got_q[$];
  int n_fail = 0, check_count = 0;
  avb_body_builder avb_body_builder_i (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .packet_flags(pflags),
    .abs_time(abs_t), .count_known(known), .tick_10mhz(tick), .body_start(body_start),
    .body_packets(body_packets), .body_busy(body_busy), .strm_data(strm_data), .strm_last(strm_last),
    .strm_valid(strm_valid), .strm_ready(strm_ready), .body_data(body_data), .body_last(body_last),
    .body_valid(body_valid), .body_ready(body_ready), .clock_ref(clock_ref));
  avb_enc_model #(.PKT_W(PKT_W)) avb_enc_model_i (.clk_sys(clk_sys), .go(go), .pkts(body_packets),
    .slow(slow), .strm_data(strm_data), .strm_last(strm_last), .strm_valid(strm_valid),
    .strm_ready(strm_ready));
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    #1;
    body_ready = hold ? 1'b0 : (toggle ? ~body_ready : 1'b1);
  end
  always @(posedge clk_sys) if (body_valid === 1'b1 && body_ready === 1'b1) got_q.push_back({body_last, body_data});
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse_ticks(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      #1;
      tick = 1'b1;
      rtc = rtc + 48'h1;
      @(posedge clk_sys);
      #1;
      tick = 1'b0;
    end
  endtask
  task automatic do_body(input logic [11:0] n, input logic dbl);
    int i, k;
    logic [63:0] ts;
    ts = pflags[6] ? abs_t : {16'h0, rtc};
    got_q.delete();
    exp_q.delete();
    exp_q.push_back({n == 12'h0, 5'h0, cfg, known ? n : 12'h0});
    for (i = 0; i < n; i++) begin
      if (cfg.per_packet_stamp_flag) begin
        exp_q.push_back({1'b0, ts[31:0]});
        exp_q.push_back({1'b0, ts[63:32]});
      end
      for (k = 0; k < PKT_W; k++) exp_q.push_back({i == n - 1 && k == PKT_W - 1, 16'h5e00 + i[15:0], k[15:0]});
    end
    @(posedge clk_sys);
    #1;
    body_packets = n;
    body_start = 1'b1;
    go = 1'b1;
    @(posedge clk_sys);
    #1;
    go = 1'b0;
    if (dbl) begin
      repeat (3) @(posedge clk_sys);
      #1;
    end
    body_start = 1'b0;
    k = 0;
    while (body_busy !== 1'b0 && k < 3000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 3000) n_fail++;
    repeat (2) @(posedge clk_sys);
    `CHK("words", exp_q.size(), got_q.size())
    foreach (exp_q[j]) if (j < got_q.size()) `CHK("word", exp_q[j], got_q[j])
  endtask
  task automatic t_fields;
    int i;
    for (i = 0; i < 16; i++) begin
      cfg = {i[0], i[3:0], i[1], i[2], i[3], i[3:0], ~i[0], ~i[1], ~i[2]};
      do_body(12'h0, 1'b0);
    end
    $display("test fields done");
  endtask
  task automatic t_packets;
    cfg = '0;
    toggle = 1'b1;
    slow = 1'b1;
    do_body(12'h3, 1'b0);
    toggle = 1'b0;
    slow = 1'b0;
    $display("test packets done");
  endtask
  task automatic t_stamps;
    cfg.per_packet_stamp_flag = 1'b1;
    pulse_ticks(5);
    do_body(12'h2, 1'b1);
    pflags = 8'h4c;
    abs_t = 64'h0123456789abcdef;
    known = 1'b0;
    do_body(12'h1, 1'b0);
    known = 1'b1;
    pflags = 8'h0;
    $display("test stamps done");
  endtask
  task automatic t_stall;
    hold = 1'b1;
    fork
      do_body(12'h4, 1'b0);
      begin
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK("strm_ready", 1'b0, strm_ready)
        hold = 1'b0;
      end
    join
    $display("test stall done");
  endtask
  task automatic t_ref;
    logic [41:0] c0;
    cfg.clock_sync_flag = 1'b1;
    repeat (3) @(posedge clk_sys);
    c0 = clock_ref;
    pulse_ticks(10);
    repeat (3) @(posedge clk_sys);
    `CHK("ref_sync", c0 + 42'h1b, clock_ref)
    `CHK("ref_to_rtc", 42'ha, ((clock_ref - c0) * 42'ha + 42'hd) / 42'h1b)
    #1;
    cfg.clock_sync_flag = 1'b0;
    repeat (3) @(posedge clk_sys);
    c0 = clock_ref;
    pulse_ticks(10);
    repeat (3) @(posedge clk_sys);
    `CHK("ref_hold", c0, clock_ref)
    $display("test ref done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_fields;
    t_packets;
    t_stamps;
    t_stall;
    t_ref;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict;
  end
endmodule // test_avc_video_packet_body_builder
